// File: include/hmt_regs.vh
`ifndef HMT_REGS_VH
`define HMT_REGS_VH

// ==========================================================
// register indices (byte address = 4 * index)
`define HMT_ADDR_W 12
`define HMT_IDX_W 10
`define HMT_IDX_HDR_HOST 10'h040
`define HMT_IDX_HDR_DEV 10'h041
`define HMT_IDX_CTRL_MSB 10'h042
`define HMT_IDX_CTRL_LSB 10'h043
`define HMT_IDX_FLAGS 10'h044
`define HMT_IDX_EVT 10'h045
`define HMT_IDX_MASK 10'h046
`define HMT_IDX_RD_IDX 10'h048
`define HMT_IDX_WR_IDX 10'h04A
`define HMT_IDX_DATA 10'h04C

// ==========================================================
// decoded register selects
`define HMT_SEL_W 4
`define HMT_SEL_NONE 4'h0
`define HMT_SEL_HDR_HOST 4'h1
`define HMT_SEL_HDR_DEV 4'h2
`define HMT_SEL_CTRL_MSB 4'h3
`define HMT_SEL_CTRL_LSB 4'h4
`define HMT_SEL_FLAGS 4'h5
`define HMT_SEL_EVT 4'h6
`define HMT_SEL_MASK 4'h7
`define HMT_SEL_RD_IDX 4'h8
`define HMT_SEL_WR_IDX 4'h9
`define HMT_SEL_DATA 4'hA

// ==========================================================
// field positions
`define HMT_FLG_HWP 0
`define HMT_FLG_DMP 1
`define HMT_FLG_IPS 2
`define HMT_EVT_W 2
`define HMT_EVT_OUT 0
`define HMT_EVT_IN 1
`define HMT_MSC_HI 5
`define HMT_MSC_LO 2
`define HMT_MSC_REQ_CFG 4'h1
`define HMT_MSC_REQ_STAT 4'h3

// ==========================================================
// reset values and bus answers
`define HMT_RST_BYTE 8'h00
`define HMT_RST_EVT 2'h0
`define HMT_RST_MASK 2'h0
`define HMT_RESP_OKAY 2'h0
`define HMT_RESP_SLVERR 2'h2

`endif

// File: src/hmt_mailbox_ram.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// mailbox byte store, one write port, two read ports
// contents survive reset and messages so unchanged bytes need no rewrite
module hmt_mailbox_ram #(
	parameter DATA_W = 8,
	parameter AW = 8,
	parameter DEPTH = 256
) (
	input wire clk, // clock
	input wire we, // write strobe
	input wire [AW-1:0] waddr, // write index
	input wire [DATA_W-1:0] wdata, // write byte
	input wire [AW-1:0] raddr_a, // host read index
	output wire [DATA_W-1:0] rdata_a, // host read byte
	input wire [AW-1:0] raddr_b, // device read index
	output wire [DATA_W-1:0] rdata_b // device read byte
);

	reg [DATA_W-1:0] mem_reg [0:DEPTH-1];

	always @(posedge clk)
	begin
		if (we)
			mem_reg[waddr] <= wdata;
	end

	assign rdata_a = mem_reg[raddr_a];
	assign rdata_b = mem_reg[raddr_b];

endmodule // hmt_mailbox_ram

`default_nettype wire

// File: src/hmt_mailbox.v
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "hmt_regs.vh"

// Operation
// - header access sets pending; device clears it
// - posted outbound message raises interrupt line
// - host reads device header first
// - low control byte carries mailbox byte count
// - each data read advances read index
// - host clearing pending flag frees mailbox
// - clearing flag unread still frees mailbox
// - responses only after matching host request
// - mask off keeps line low, status set
// - config or status request both open a pending request
// - zeroed write index advances per byte
// - old mailbox bytes stay unchanged
module hmt_mailbox #(
	parameter MBX_AW = 8,
	parameter MBX_DEPTH = 256
) (
	input wire aclk, // clock
	input wire aresetn, // sync reset, low
	input wire [`HMT_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire [2:0] s_axi_awprot, // unused protection
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // byte enables
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [`HMT_ADDR_W-1:0] s_axi_araddr, // read address
	input wire [2:0] s_axi_arprot, // unused protection
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	output wire irq, // interrupt, high active level
	output reg in_valid, // inbound message handed over, pulse
	output wire [7:0] in_header, // inbound header byte
	output wire [7:0] in_ctrl_msb, // inbound control high
	output wire [7:0] in_ctrl_lsb, // inbound byte count
	input wire in_done, // device consumed inbound, pulse
	output wire req_pending, // host request awaits response
	output wire [7:0] req_header, // header of the last handed-over message, request or not
	input wire [MBX_AW-1:0] dev_rd_addr, // device mailbox read index
	output wire [7:0] dev_rd_data, // device mailbox read byte
	input wire dev_wr_en, // device mailbox write
	input wire [MBX_AW-1:0] dev_wr_addr, // device mailbox write index
	input wire [7:0] dev_wr_data, // device mailbox write byte
	output wire dev_wr_ready, // device write taken this cycle
	input wire post_valid, // post outbound message
	input wire post_resp, // message is a response
	input wire [7:0] post_header, // outbound header byte
	input wire [7:0] post_ctrl_msb, // outbound control high
	input wire [7:0] post_ctrl_lsb, // outbound byte count
	output wire post_ready // outbound message accepted
);

	// ==========================================================
	// address decode, shared by read and write channels
	function [`HMT_SEL_W-1:0] reg_sel;
		input [`HMT_ADDR_W-1:0] addr;
		begin
			reg_sel = `HMT_SEL_NONE;
			if (addr[1:0] == 2'h0)
			begin
				case (addr[`HMT_ADDR_W-1:2])
					`HMT_IDX_HDR_HOST: reg_sel = `HMT_SEL_HDR_HOST;
					`HMT_IDX_HDR_DEV: reg_sel = `HMT_SEL_HDR_DEV;
					`HMT_IDX_CTRL_MSB: reg_sel = `HMT_SEL_CTRL_MSB;
					`HMT_IDX_CTRL_LSB: reg_sel = `HMT_SEL_CTRL_LSB;
					`HMT_IDX_FLAGS: reg_sel = `HMT_SEL_FLAGS;
					`HMT_IDX_EVT: reg_sel = `HMT_SEL_EVT;
					`HMT_IDX_MASK: reg_sel = `HMT_SEL_MASK;
					`HMT_IDX_RD_IDX: reg_sel = `HMT_SEL_RD_IDX;
					`HMT_IDX_WR_IDX: reg_sel = `HMT_SEL_WR_IDX;
					`HMT_IDX_DATA: reg_sel = `HMT_SEL_DATA;
					default: reg_sel = `HMT_SEL_NONE;
				endcase
			end
		end
	endfunction

	// ==========================================================
	// state
	reg [`HMT_ADDR_W-1:0] awaddr_reg;
	reg aw_full_reg;
	reg [7:0] wbyte_reg;
	reg wlane_reg;
	reg w_full_reg;
	reg [7:0] host_hdr_reg;
	reg [7:0] in_msb_reg;
	reg [7:0] in_lsb_reg;
	reg [7:0] dev_hdr_reg;
	reg [7:0] out_msb_reg;
	reg [7:0] out_lsb_reg;
	reg hwp_reg;
	reg hwp_next;
	reg dmp_reg;
	reg dmp_next;
	reg req_pend_reg;
	reg req_pend_next;
	reg [7:0] req_hdr_reg;
	reg [`HMT_EVT_W-1:0] evt_reg;
	reg [`HMT_EVT_W-1:0] evt_next;
	reg [`HMT_EVT_W-1:0] mask_reg;
	reg [MBX_AW-1:0] rd_idx_reg;
	reg [MBX_AW-1:0] rd_idx_next;
	reg [MBX_AW-1:0] wr_idx_reg;
	reg [MBX_AW-1:0] wr_idx_next;
	reg [31:0] rdata_next;
	reg [1:0] rresp_next;

	wire [`HMT_SEL_W-1:0] sel_w;
	wire [`HMT_SEL_W-1:0] sel_r;
	wire exec_wr;
	wire ar_hs;
	wire wr_ok;
	wire hdr_touch;
	wire take_post;
	wire dmp_clear;
	wire host_we;
	wire mem_we;
	wire [MBX_AW-1:0] mem_waddr;
	wire [7:0] mem_wdata;
	wire [7:0] host_rd_byte;
	wire [7:0] flags_byte;
	wire [3:0] hdr_msc;
	wire [7:0] hdr_now;
	wire is_request;

	// ==========================================================
	// AXI4-Lite handshakes
	// address and data are parked separately so either may come first
	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready = !w_full_reg;
	assign exec_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_hs = s_axi_arvalid && !s_axi_rvalid;
	assign sel_w = reg_sel(awaddr_reg);
	assign sel_r = reg_sel(s_axi_araddr);
	assign wr_ok = exec_wr && wlane_reg;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_reg <= {`HMT_ADDR_W{1'b0}};
			aw_full_reg <= 1'b0;
			wbyte_reg <= `HMT_RST_BYTE;
			wlane_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `HMT_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `HMT_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_reg)
			begin
				awaddr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
			end
			else if (exec_wr)
				aw_full_reg <= 1'b0;
			if (s_axi_wvalid && !w_full_reg)
			begin
				wbyte_reg <= s_axi_wdata[7:0];
				wlane_reg <= s_axi_wstrb[0];
				w_full_reg <= 1'b1;
			end
			else if (exec_wr)
				w_full_reg <= 1'b0;
			if (exec_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (sel_w == `HMT_SEL_NONE) ? `HMT_RESP_SLVERR : `HMT_RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (ar_hs)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_next;
				s_axi_rresp <= rresp_next;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// read data mux
	assign flags_byte = {5'h00, dmp_reg, dmp_reg, hwp_reg};

	always @*
	begin
		rdata_next = 32'h00000000;
		rresp_next = `HMT_RESP_OKAY;
		case (sel_r)
			`HMT_SEL_HDR_HOST: rdata_next[7:0] = host_hdr_reg;
			`HMT_SEL_HDR_DEV: rdata_next[7:0] = dev_hdr_reg;
			`HMT_SEL_CTRL_MSB: rdata_next[7:0] = out_msb_reg;
			`HMT_SEL_CTRL_LSB: rdata_next[7:0] = out_lsb_reg;
			`HMT_SEL_FLAGS: rdata_next[7:0] = flags_byte;
			`HMT_SEL_EVT: rdata_next[`HMT_EVT_W-1:0] = evt_reg;
			`HMT_SEL_MASK: rdata_next[`HMT_EVT_W-1:0] = mask_reg;
			`HMT_SEL_RD_IDX: rdata_next[MBX_AW-1:0] = rd_idx_reg;
			`HMT_SEL_WR_IDX: rdata_next[MBX_AW-1:0] = wr_idx_reg;
			`HMT_SEL_DATA: rdata_next[7:0] = host_rd_byte;
			default: rresp_next = `HMT_RESP_SLVERR;
		endcase
	end

	// ==========================================================
	// inbound handover and request tracking
	// any access to the host header, read or write, hands the message over
	assign hdr_touch = (exec_wr && sel_w == `HMT_SEL_HDR_HOST)
		|| (ar_hs && sel_r == `HMT_SEL_HDR_HOST);
	// a header written at the touching edge is not in the register yet
	assign hdr_now = (wr_ok && sel_w == `HMT_SEL_HDR_HOST) ? wbyte_reg : host_hdr_reg;
	assign hdr_msc = hdr_now[`HMT_MSC_HI:`HMT_MSC_LO];
	assign is_request = (hdr_msc == `HMT_MSC_REQ_CFG) || (hdr_msc == `HMT_MSC_REQ_STAT);

	// ==========================================================
	// outbound posting
	// a response needs an outstanding request; events go whenever the mailbox is free
	assign post_ready = !dmp_reg && (!post_resp || req_pend_reg);
	assign take_post = post_valid && post_ready;
	assign dmp_clear = wr_ok && sel_w == `HMT_SEL_FLAGS && !wbyte_reg[`HMT_FLG_DMP];

	always @*
	begin
		hwp_next = hwp_reg;
		if (in_done)
			hwp_next = 1'b0;
		if (hdr_touch)
			hwp_next = 1'b1;
		dmp_next = dmp_reg;
		if (dmp_clear)
			dmp_next = 1'b0;
		if (take_post)
			dmp_next = 1'b1;
		req_pend_next = req_pend_reg;
		if (take_post && post_resp)
			req_pend_next = 1'b0;
		if (hdr_touch && !hwp_reg && is_request)
			req_pend_next = 1'b1;
		evt_next = evt_reg;
		if (ar_hs && sel_r == `HMT_SEL_EVT)
			evt_next = `HMT_RST_EVT;
		if (dmp_clear)
			evt_next[`HMT_EVT_OUT] = 1'b0;
		if (take_post)
			evt_next[`HMT_EVT_OUT] = 1'b1;
		if (in_done && hwp_reg)
			evt_next[`HMT_EVT_IN] = 1'b1;
	end

	// ==========================================================
	// index registers
	// a host write to an index wins over an advance in the same cycle
	always @*
	begin
		rd_idx_next = rd_idx_reg;
		if (ar_hs && sel_r == `HMT_SEL_DATA)
			rd_idx_next = rd_idx_reg + 1'b1;
		if (wr_ok && sel_w == `HMT_SEL_RD_IDX)
			rd_idx_next = wbyte_reg[MBX_AW-1:0];
		wr_idx_next = wr_idx_reg;
		if (wr_ok && sel_w == `HMT_SEL_DATA)
			wr_idx_next = wr_idx_reg + 1'b1;
		if (wr_ok && sel_w == `HMT_SEL_WR_IDX)
			wr_idx_next = wbyte_reg[MBX_AW-1:0];
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			host_hdr_reg <= `HMT_RST_BYTE;
			in_msb_reg <= `HMT_RST_BYTE;
			in_lsb_reg <= `HMT_RST_BYTE;
			dev_hdr_reg <= `HMT_RST_BYTE;
			out_msb_reg <= `HMT_RST_BYTE;
			out_lsb_reg <= `HMT_RST_BYTE;
			hwp_reg <= 1'b0;
			dmp_reg <= 1'b0;
			req_pend_reg <= 1'b0;
			req_hdr_reg <= `HMT_RST_BYTE;
			evt_reg <= `HMT_RST_EVT;
			mask_reg <= `HMT_RST_MASK;
			rd_idx_reg <= {MBX_AW{1'b0}};
			wr_idx_reg <= {MBX_AW{1'b0}};
			in_valid <= 1'b0;
		end
		else
		begin
			hwp_reg <= hwp_next;
			dmp_reg <= dmp_next;
			req_pend_reg <= req_pend_next;
			evt_reg <= evt_next;
			rd_idx_reg <= rd_idx_next;
			wr_idx_reg <= wr_idx_next;
			// a second header touch while pending is not delivered twice
			in_valid <= hdr_touch && !hwp_reg;
			if (hdr_touch && !hwp_reg)
				req_hdr_reg <= hdr_now;
			if (wr_ok && sel_w == `HMT_SEL_HDR_HOST)
				host_hdr_reg <= wbyte_reg;
			if (wr_ok && sel_w == `HMT_SEL_CTRL_MSB)
				in_msb_reg <= wbyte_reg;
			if (wr_ok && sel_w == `HMT_SEL_CTRL_LSB)
				in_lsb_reg <= wbyte_reg;
			if (wr_ok && sel_w == `HMT_SEL_MASK)
				mask_reg <= wbyte_reg[`HMT_EVT_W-1:0];
			if (take_post)
			begin
				dev_hdr_reg <= post_header;
				out_msb_reg <= post_ctrl_msb;
				out_lsb_reg <= post_ctrl_lsb;
			end
		end
	end

	// ==========================================================
	// mailbox store; host data writes take the port over device writes
	assign host_we = wr_ok && sel_w == `HMT_SEL_DATA;
	assign dev_wr_ready = !host_we;
	assign mem_we = host_we || dev_wr_en;
	assign mem_waddr = host_we ? wr_idx_reg : dev_wr_addr;
	assign mem_wdata = host_we ? wbyte_reg : dev_wr_data;

	hmt_mailbox_ram #(
		.DATA_W(8),
		.AW(MBX_AW),
		.DEPTH(MBX_DEPTH)
	) u_ram (
		.clk(aclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr_a(rd_idx_reg),
		.rdata_a(host_rd_byte),
		.raddr_b(dev_rd_addr),
		.rdata_b(dev_rd_data)
	);

	// ==========================================================
	// outputs
	// mask gates only the line; pending status is set either way
	assign irq = |(evt_reg & mask_reg);
	assign in_header = host_hdr_reg;
	assign in_ctrl_msb = in_msb_reg;
	assign in_ctrl_lsb = in_lsb_reg;
	assign req_pending = req_pend_reg;
	assign req_header = req_hdr_reg;

endmodule // hmt_mailbox

`default_nettype wire

// File: verification/hmt_mailbox_chk.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// port-level checks
module hmt_mailbox_chk (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, low
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic in_valid, // handover pulse
	input wire logic post_valid, // post offered
	input wire logic post_resp, // post is response
	input wire logic post_ready, // post taken
	input wire logic req_pending // request open
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid stuck");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read answer late");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped early");
	a_handover_once: assert property (in_valid |=> !in_valid)
		else $error("second handover while pending");
	a_post_blocks: assert property (post_valid && post_ready |=> !post_ready)
		else $error("mailbox taken while occupied");
	a_resp_gated: assert property (post_resp && !req_pending |-> !post_ready)
		else $error("response without request");

	c_handover: cover property (in_valid);
	c_resp_post: cover property (post_valid && post_ready && post_resp);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // hmt_mailbox_chk

bind hmt_mailbox hmt_mailbox_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .in_valid, .post_valid, .post_resp,
	.post_ready, .req_pending);

`default_nettype wire

// File: verification/hmt_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// device core: consumes each inbound message, answers with one
module hmt_core_model #(
	parameter logic [7:0] OUT_HDR = 8'h45,
	parameter logic [7:0] OUT_B0 = 8'hA5,
	parameter logic [7:0] OUT_B1 = 8'h5A
) (
	input wire logic aclk, // clock
	input wire logic in_valid, // handover pulse
	input wire logic [7:0] in_header, // inbound header
	input wire logic [7:0] in_ctrl_lsb, // inbound count
	output logic in_done, // consumed pulse
	input wire logic req_pending, // request open
	output logic [7:0] dev_rd_addr, // store read index
	input wire logic [7:0] dev_rd_data, // store read byte
	output logic dev_wr_en, // store write
	output logic [7:0] dev_wr_addr, // store write index
	output logic [7:0] dev_wr_data, // store write byte
	input wire logic dev_wr_ready, // write taken
	output logic post_valid, // post offered
	output logic post_resp, // post is response
	output logic [7:0] post_header, // outbound header
	output logic [7:0] post_ctrl_msb, // outbound ctrl high
	output logic [7:0] post_ctrl_lsb, // outbound count
	input wire logic post_ready, // post taken
	output logic [7:0] got_hdr, // captured header
	output logic [7:0] got_lsb, // captured count
	output logic [23:0] got_data // first three bytes
);
	integer i;

	initial
	begin
		in_done = 1'b0;
		dev_rd_addr = 8'h00;
		dev_wr_en = 1'b0;
		dev_wr_addr = 8'h00;
		dev_wr_data = 8'h00;
		post_valid = 1'b0;
		post_resp = 1'b0;
		post_header = 8'h00;
		post_ctrl_msb = 8'h01;
		post_ctrl_lsb = 8'h02;
		forever
		begin
			@(posedge aclk);
			if (in_valid === 1'b1)
			begin
				got_hdr = in_header;
				got_lsb = in_ctrl_lsb;
				for (i = 0; i < 3; i++)
				begin
					dev_rd_addr <= i[7:0];
					@(posedge aclk);
					got_data[8*i +: 8] = dev_rd_data;
				end
				for (i = 0; i < 2; i++)
				begin
					dev_wr_en <= 1'b1;
					dev_wr_addr <= i[7:0];
					dev_wr_data <= (i == 0) ? OUT_B0 : OUT_B1;
					do @(posedge aclk); while (dev_wr_ready !== 1'b1);
				end
				dev_wr_en <= 1'b0;
				// released lines must not keep their last value
				dev_wr_data <= ~OUT_B1;
				in_done <= 1'b1;
				@(posedge aclk);
				in_done <= 1'b0;
				post_valid <= 1'b1;
				post_resp <= req_pending;
				post_header <= OUT_HDR;
				do @(posedge aclk); while (post_ready !== 1'b1);
				post_valid <= 1'b0;
				post_header <= ~OUT_HDR;
			end
		end
	end
endmodule // hmt_core_model

`default_nettype wire

// File: verification/hmt_mailbox_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "hmt_regs.vh"

module hmt_mailbox_tb;
	localparam logic [7:0] OUT_HDR = 8'h45;
	localparam logic [7:0] OUT_B0 = 8'hA5;
	localparam logic [7:0] OUT_B1 = 8'h5A;
	localparam logic [11:0] A_HH = {`HMT_IDX_HDR_HOST, 2'b00};
	localparam logic [11:0] A_HD = {`HMT_IDX_HDR_DEV, 2'b00};
	localparam logic [11:0] A_MSB = {`HMT_IDX_CTRL_MSB, 2'b00};
	localparam logic [11:0] A_LSB = {`HMT_IDX_CTRL_LSB, 2'b00};
	localparam logic [11:0] A_FLG = {`HMT_IDX_FLAGS, 2'b00};
	localparam logic [11:0] A_EVT = {`HMT_IDX_EVT, 2'b00};
	localparam logic [11:0] A_MSK = {`HMT_IDX_MASK, 2'b00};
	localparam logic [11:0] A_RI = {`HMT_IDX_RD_IDX, 2'b00};
	localparam logic [11:0] A_WI = {`HMT_IDX_WR_IDX, 2'b00};
	localparam logic [11:0] A_DAT = {`HMT_IDX_DATA, 2'b00};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire logic in_valid, in_done, req_pending, dev_wr_en, dev_wr_ready, post_valid;
	wire logic post_resp, post_ready;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0] in_header, in_ctrl_msb, in_ctrl_lsb, req_header, dev_rd_data;
	wire logic [7:0] dev_wr_data, post_header, post_ctrl_msb, post_ctrl_lsb, got_hdr, got_lsb;
	wire logic [7:0] dev_rd_addr, dev_wr_addr;
	wire logic [23:0] got_data;
	int bad_count = 0;
	int check_count = 0;
	logic [31:0] d;
	logic [1:0] r;

	hmt_mailbox dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .irq, .in_valid, .in_header, .in_ctrl_msb, .in_ctrl_lsb, .in_done,
		.req_pending, .req_header, .dev_rd_addr, .dev_rd_data, .dev_wr_en, .dev_wr_addr,
		.dev_wr_data, .dev_wr_ready, .post_valid, .post_resp, .post_header, .post_ctrl_msb,
		.post_ctrl_lsb, .post_ready);
	hmt_core_model #(.OUT_HDR(OUT_HDR), .OUT_B0(OUT_B0), .OUT_B1(OUT_B1)) partner (.aclk,
		.in_valid, .in_header, .in_ctrl_lsb, .in_done, .req_pending, .dev_rd_addr,
		.dev_rd_data, .dev_wr_en, .dev_wr_addr, .dev_wr_data, .dev_wr_ready, .post_valid,
		.post_resp, .post_header, .post_ctrl_msb, .post_ctrl_lsb, .post_ready, .got_hdr,
		.got_lsb, .got_data);

	// ==========================================================
	// helpers
	task automatic summarize();
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// waits an edge first so back-to-back calls never touch a signal twice at once
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
	endtask

	task automatic inbound(input logic [7:0] h, input logic [7:0] n, input logic [23:0] b);
		int i;
		do
			rd(A_FLG);
		while (d[`HMT_FLG_HWP] !== 1'b0);
		wr(A_MSB, ~n);
		wr(A_LSB, n);
		wr(A_WI, 8'h00);
		for (i = 0; i < n; i++)
			wr(A_DAT, b[8*i +: 8]);
		wr(A_HH, h);
	endtask

	// ==========================================================
	// clock, watchdog, tests
	initial
	begin
		forever #2 aclk = ~aclk;
	end

	initial
	begin
		#40000;
		bad_count++;
		summarize();
	end

	initial
	begin
		int k;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rc("flags", A_FLG, 32'h0);
		rc("mask", A_MSK, 32'h0);
		rc("events", A_EVT, 32'h0);
		wr(A_MSK, 8'h01);
		inbound(8'h44, 8'd3, 24'h332211);
		rc("flags", A_FLG, 32'h1);
		chk("req open", 32'h1, req_pending);
		for (k = 0; k < 60 && irq !== 1'b1; k++)
			@(posedge aclk);
		chk("irq", 32'h1, irq);
		chk("in header", 32'h44, got_hdr);
		chk("in count", 32'h3, got_lsb);
		chk("in bytes", 32'h332211, got_data);
		chk("req header", 32'h44, req_header);
		chk("req closed", 32'h0, req_pending);
		chk("in msb", 32'hFC, in_ctrl_msb);
		rc("flags", A_FLG, 32'h6);
		rc("dev header", A_HD, OUT_HDR);
		rc("count", A_LSB, 32'h2);
		rc("ctrl msb", A_MSB, 32'h1);
		wr(A_RI, 8'h00);
		rc("byte0", A_DAT, OUT_B0);
		rc("byte1", A_DAT, OUT_B1);
		rc("rd index", A_RI, 32'h2);
		wr(A_FLG, 8'h00);
		chk("irq", 32'h0, irq);
		rc("flags", A_FLG, 32'h0);
		rc("events", A_EVT, 32'h2);
		rc("events", A_EVT, 32'h0);
		wr(A_MSK, 8'h00);
		inbound(8'h64, 8'd1, 24'h000077);
		k = 0;
		do
		begin
			rd(A_FLG);
			k++;
		end
		while (d[1] !== 1'b1 && k < 30);
		chk("flags", 32'h6, d);
		chk("irq", 32'h0, irq);
		chk("in bytes", {8'h00, 8'h33, OUT_B1, 8'h77}, got_data);
		wr(A_FLG, 8'h00);
		rc("flags", A_FLG, 32'h0);
		wr(A_MSK, 8'h03);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc("mask", A_MSK, 32'h0);
		rc("events", A_EVT, 32'h0);
		rc("bad read", 12'h3FC, 32'h0);
		chk("bad read resp", `HMT_RESP_SLVERR, r);
		rd(12'h101);
		chk("unaligned resp", `HMT_RESP_SLVERR, r);
		wr(12'h3FC, 8'h5A);
		chk("bad write resp", `HMT_RESP_SLVERR, r);
		summarize();
	end
endmodule // hmt_mailbox_tb

`default_nettype wire
